// >>> src/stp_pkg.sv
// Shared constants, types and helpers for the step attenuator control port
package stp_pkg;

    localparam int STP_FRAME_W = 16;
    localparam int STP_BYTE_W = 8;
    localparam int STP_ATTEN_W = 6;
    localparam int STP_ADDR_W = 3;

    // Field positions inside the received frame
    localparam int STP_ATT_LSB = 0;
    localparam int STP_ATT_PAD_LSB = 6;
    localparam int STP_ADDR_LSB = 8;

    // One code step is a quarter dB; code 6'h3f is 15.75 dB
    localparam int STP_STEP_MILLI_DB = 250;
    localparam logic [5:0] STP_POWER_ON_DEFAULT = 6'h3f;
    localparam logic [1:0] STP_PAD_CLEAR = 2'h0;

    // Synchroniser depth on the core clock
    localparam int STP_SYNC_STAGES = 2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_OPEN = 2'b01,
        ST_CLOSE = 2'b11
    } stp_state_e;

    // Slow control pins as seen by the core clock
    typedef struct packed {
        logic latch;
        logic mode_serial;
        logic [2:0] strap;
        logic [5:0] par;
    } stp_pins_s;

    // Serial frame: address byte above, attenuation byte below
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] atten;
    } stp_frame_s;

    function automatic logic stp_addr_hit(input stp_frame_s f, input logic [2:0] strap);
        stp_addr_hit = (f.addr[STP_ADDR_W-1:0] == strap);
    endfunction

    function automatic logic stp_pad_clear(input stp_frame_s f);
        stp_pad_clear = (f.atten[STP_BYTE_W-1:STP_ATT_PAD_LSB] == STP_PAD_CLEAR);
    endfunction

endpackage

// >>> src/stp_sync.sv
// Two-stage synchroniser for a group of slow levels
`timescale 1ns/1ps
module stp_sync
    import stp_pkg::*;
#(
    parameter int W = 1
) (
    // Destination clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Levels in and out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end

endmodule

// >>> src/stp_shift.sv
// Serial-clock domain shift register with a shift-event toggle
`timescale 1ns/1ps
module stp_shift
    import stp_pkg::*;
(
    // Link clock and core reset
    input wire logic serial_clk,
    input wire logic nrst,
    // Serial data
    input wire logic serial_data,
    // Shifted frame and event toggle
    output stp_frame_s frame_q,
    output logic shift_tog_q
);

    logic rst_meta_q;
    logic rst_n_q;

    // Reset brought into the link domain
    always_ff @(posedge serial_clk) begin
        rst_meta_q <= nrst;
        rst_n_q <= rst_meta_q;
    end

    // New bit enters at the top, so the first bit sent ends at bit 0
    // No reset: the link reset releases two edges late and would swallow the first bits
    always_ff @(posedge serial_clk) begin
        frame_q <= {serial_data, frame_q[STP_FRAME_W-1:1]};
    end

    // Flips on every shift so the core can tell the word is still moving
    always_ff @(posedge serial_clk) begin
        if (!rst_n_q) begin
            shift_tog_q <= 1'b0;
        end else begin
            shift_tog_q <= ~shift_tog_q;
        end
    end

endmodule

// >>> src/stp_ctrl.sv
// Control port of a 6-bit step attenuator: parallel and serial-addressable loading
`timescale 1ns/1ps
module stp_ctrl
    import stp_pkg::*;
(
    // Core clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Serial link
    input wire logic serial_clk,
    input wire logic serial_data,
    input wire logic latch_strobe,
    // Interface select
    input wire logic mode_serial,
    // Parallel weight bits
    input wire logic weight_bit_quarter_db,
    input wire logic weight_bit_half_db,
    input wire logic weight_bit_1db,
    input wire logic weight_bit_2db,
    input wire logic weight_bit_4db,
    input wire logic weight_bit_8db,
    // Address straps
    input wire logic addr_strap_bit0,
    input wire logic addr_strap_bit1,
    input wire logic addr_strap_bit2,
    // Attenuator core setting
    output logic [5:0] atten_code_q,
    // Status
    output logic update_q,
    output logic mismatch_q,
    output logic reject_q,
    output logic latch_open_q,
    output logic mode_serial_q
);

    stp_pins_s pins_raw;
    stp_pins_s pins_s;
    stp_frame_s frame_link;
    logic tog_link;
    stp_frame_s frame_s;
    logic tog_s;
    stp_frame_s frame_prev_q;
    logic tog_prev_q;
    logic word_stable;
    logic frame_hit;
    logic frame_clean;
    logic [5:0] par_code;
    logic [5:0] frame_code;
    stp_state_e state_q;
    stp_state_e state_d;
    logic load_en;
    logic [5:0] load_code;
    logic hit_seen_q;
    logic bad_seen_q;

    // Pins grouped for the core-clock synchroniser
    always_comb begin
        pins_raw.latch = latch_strobe;
        pins_raw.mode_serial = mode_serial;
        pins_raw.strap = {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};
        pins_raw.par = {weight_bit_8db, weight_bit_4db, weight_bit_2db,
                        weight_bit_1db, weight_bit_half_db, weight_bit_quarter_db};
    end

    stp_sync #(
        .W($bits(stp_pins_s))
    ) u_pin_sync (
        .clk(mclk),
        .rst_n(nrst),
        .d(pins_raw),
        .q(pins_s)
    );

    // Link domain: shifting runs on the serial clock alone
    stp_shift u_shift (
        .serial_clk(serial_clk),
        .nrst(nrst),
        .serial_data(serial_data),
        .frame_q(frame_link),
        .shift_tog_q(tog_link)
    );

    // Frame word and shift toggle cross together; the word is quasi-static once shifting stops
    stp_sync #(
        .W(STP_FRAME_W + 1)
    ) u_frame_sync (
        .clk(mclk),
        .rst_n(nrst),
        .d({tog_link, frame_link}),
        .q({tog_s, frame_s})
    );

    // Previous sample, so a word caught mid-change is never used
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            frame_prev_q <= '0;
            tog_prev_q <= 1'b0;
        end else begin
            frame_prev_q <= frame_s;
            tog_prev_q <= tog_s;
        end
    end

    assign word_stable = (frame_s == frame_prev_q) && (tog_s == tog_prev_q);

    // Frame decode: three address bits matter, the top five are ignored
    assign frame_hit = stp_addr_hit(frame_s, pins_s.strap);
    assign frame_clean = stp_pad_clear(frame_s);
    assign frame_code = frame_s.atten[STP_ATT_LSB +: STP_ATTEN_W];
    assign par_code = pins_s.par;

    // Strobe sequencing
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (pins_s.latch) begin
                    state_d = ST_OPEN;
                end
            end
            ST_OPEN: begin
                if (!pins_s.latch) begin
                    state_d = ST_CLOSE;
                end
            end
            ST_CLOSE: begin
                state_d = pins_s.latch ? ST_OPEN : ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Source selection while the strobe is high
    always_comb begin
        load_en = 1'b0;
        load_code = par_code;
        if (pins_s.latch) begin
            if (!pins_s.mode_serial) begin
                load_en = 1'b1;
                load_code = par_code;
            end else if (word_stable && frame_hit && frame_clean) begin
                load_en = 1'b1;
                load_code = frame_code;
            end
        end
    end

    // Core setting: maximum attenuation until the first load
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            atten_code_q <= STP_POWER_ON_DEFAULT;
        end else if (load_en) begin
            atten_code_q <= load_code;
        end
    end

    // One-cycle pulse whenever the core setting actually changes
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            update_q <= 1'b0;
        end else begin
            update_q <= load_en && (load_code != atten_code_q);
        end
    end

    // Track what a serial strobe pulse found while open
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            hit_seen_q <= 1'b0;
            bad_seen_q <= 1'b0;
        end else if (state_q == ST_IDLE || state_q == ST_CLOSE) begin
            hit_seen_q <= 1'b0;
            bad_seen_q <= 1'b0;
        end else if (pins_s.mode_serial && word_stable) begin
            if (frame_hit) begin
                hit_seen_q <= 1'b1;
            end
            if (frame_hit && !frame_clean) begin
                bad_seen_q <= 1'b1;
            end
        end
    end

    // Pulses at strobe fall: address missed, or matched with padding bits set
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            mismatch_q <= 1'b0;
            reject_q <= 1'b0;
        end else begin
            mismatch_q <= (state_q == ST_OPEN) && !pins_s.latch && pins_s.mode_serial && !hit_seen_q;
            reject_q <= (state_q == ST_OPEN) && !pins_s.latch && pins_s.mode_serial && bad_seen_q;
        end
    end

    // Level status
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            latch_open_q <= 1'b0;
            mode_serial_q <= 1'b0;
        end else begin
            latch_open_q <= pins_s.latch;
            mode_serial_q <= pins_s.mode_serial;
        end
    end

endmodule

// >>> dv/stp_ctrl_assertions.sv
// Output checks for the step attenuator control port
`timescale 1ns/1ps
module stp_ctrl_assertions
    import stp_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Watched outputs
    input wire logic [5:0] atten_code_q,
    input wire logic update_q,
    input wire logic mismatch_q,
    input wire logic reject_q,
    input wire logic latch_open_q,
    input wire logic mode_serial_q
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    sequence s_moved;
        $changed(atten_code_q);
    endsequence
    sequence s_refused;
        mismatch_q || reject_q;
    endsequence
    // Reset checks must see the reset cycles themselves
    property p_rst_code;
        disable iff (1'b0) !nrst |=> atten_code_q == STP_POWER_ON_DEFAULT;
    endproperty
    property p_rst_quiet;
        disable iff (1'b0) !nrst |=> !update_q && !mismatch_q && !reject_q;
    endproperty
    property p_upd_follows;
        s_moved |-> update_q;
    endproperty
    property p_move_needs_latch;
        s_moved |-> latch_open_q;
    endproperty
    property p_upd_after_latch;
        update_q |-> latch_open_q ##0 s_moved;
    endproperty
    property p_mis_keeps;
        mismatch_q |-> $stable(atten_code_q) && !update_q;
    endproperty
    property p_rej_keeps;
        reject_q |-> $stable(atten_code_q);
    endproperty
    property p_refuse_serial;
        s_refused |-> mode_serial_q;
    endproperty
    a_rst_code: assert property (p_rst_code) else $error("reset code");
    a_rst_quiet: assert property (p_rst_quiet) else $error("reset pulse");
    a_upd_follows: assert property (p_upd_follows) else $error("no update");
    a_move_needs_latch: assert property (p_move_needs_latch) else $error("unlatched");
    a_upd_after_latch: assert property (p_upd_after_latch) else $error("late update");
    a_mis_keeps: assert property (p_mis_keeps) else $error("miss moved");
    a_rej_keeps: assert property (p_rej_keeps) else $error("reject moved");
    a_refuse_serial: assert property (p_refuse_serial) else $error("parallel refuse");
endmodule

bind stp_ctrl stp_ctrl_assertions u_chk (.mclk(mclk), .nrst(nrst), .atten_code_q(atten_code_q),
    .update_q(update_q), .mismatch_q(mismatch_q), .reject_q(reject_q),
    .latch_open_q(latch_open_q), .mode_serial_q(mode_serial_q));

// >>> dv/stp_link_model.sv
// Controller model driving the serial link and latch pins
`timescale 1ns/1ps
module stp_link_model #(
    parameter int GAP_NS = 40000
) (
    // Link pins
    output logic serial_clk,
    output logic serial_data,
    output logic latch_strobe
);
    time last_t = 0;
    initial begin
        serial_clk = 1'b0;
        serial_data = 1'b0;
        latch_strobe = 1'b0;
    end
    // Clock idles low; released data shows the inverse of its last bit
    task automatic send(input logic [31:0] w, input int n);
        #1.3;
        for (int i = 0; i < n; i++) begin
            serial_data = w[i];
            #1.5 serial_clk = 1'b1;
            #3 serial_clk = 1'b0;
            #1.5;
        end
        serial_data = ~serial_data;
    endtask
    function automatic bit rate_ok();
        return $time >= last_t + GAP_NS;
    endfunction
    task automatic set_le(input logic v);
        if (v && !latch_strobe) last_t = $time;
        latch_strobe = v;
    endtask
endmodule

// >>> dv/tb_top.sv
// Testbench for the step attenuator control port
`timescale 1ns/1ps
module tb_top;
    import stp_pkg::*;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic mode_serial = 1'b0;
    logic [5:0] par = 6'h00;
    logic [2:0] strap = 3'h0;
    logic serial_clk, serial_data, latch_strobe;
    logic [5:0] atten_code_q;
    logic update_q, mismatch_q, reject_q, latch_open_q, mode_serial_q;
    int num_errors = 0;
    int samples_checked = 0;
    int n_mis = 0;
    int n_rej = 0;
    int n_upd = 0;
    always #10 mclk = ~mclk;
    always @(negedge mclk) begin
        if (mismatch_q === 1'b1) n_mis++;
        if (reject_q === 1'b1) n_rej++;
        if (update_q === 1'b1) n_upd++;
    end
    stp_link_model lm (.serial_clk(serial_clk), .serial_data(serial_data), .latch_strobe(latch_strobe));
    stp_ctrl dut (.mclk(mclk), .nrst(nrst), .serial_clk(serial_clk), .serial_data(serial_data),
        .latch_strobe(latch_strobe), .mode_serial(mode_serial), .weight_bit_quarter_db(par[0]),
        .weight_bit_half_db(par[1]), .weight_bit_1db(par[2]), .weight_bit_2db(par[3]),
        .weight_bit_4db(par[4]), .weight_bit_8db(par[5]), .addr_strap_bit0(strap[0]),
        .addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]), .atten_code_q(atten_code_q),
        .update_q(update_q), .mismatch_q(mismatch_q), .reject_q(reject_q),
        .latch_open_q(latch_open_q), .mode_serial_q(mode_serial_q));
    task automatic chk_bits(input logic [5:0] got, input logic [5:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_cnt(input int got, input int exp);
        samples_checked++;
        if (got != exp) begin
            num_errors++;
            $display("mismatch t=%0t count %0d exp %0d", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic pulse;
        while (!lm.rate_ok()) cyc(1);
        lm.set_le(1'b1);
        cyc(6);
        lm.set_le(1'b0);
        cyc(6);
    endtask
    task automatic frame(input logic [7:0] adr, input logic [7:0] att);
        lm.send({16'h0000, adr, att}, 16);
        cyc(2);
        pulse();
    endtask
    task automatic t_par;
        int mdb;
        logic [5:0] prev = STP_POWER_ON_DEFAULT;
        logic [5:0] v[8] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h3f};
        int wt[6] = '{250, 500, 1000, 2000, 4000, 8000};
        int u = n_upd;
        chk_bits(atten_code_q, STP_POWER_ON_DEFAULT);
        for (int i = 0; i < 8; i++) begin
            par = v[i];
            cyc(8);
            chk_bits(atten_code_q, prev);
            pulse();
            mdb = 0;
            for (int b = 0; b < 6; b++) if (v[i][b]) mdb += wt[b];
            chk_bits(atten_code_q, 6'(mdb / STP_STEP_MILLI_DB));
            prev = v[i];
        end
        chk_cnt(n_upd, u + 8);
        $display("parallel latched done");
    endtask
    task automatic t_direct;
        logic [5:0] v[3] = '{6'h2a, 6'h15, 6'h00};
        while (!lm.rate_ok()) cyc(1);
        lm.set_le(1'b1);
        for (int i = 0; i < 3; i++) begin
            par = v[i];
            cyc(6);
            chk_bits(atten_code_q, v[i]);
            cyc(2000);
        end
        chk_bits({5'h00, latch_open_q}, 6'h01);
        lm.set_le(1'b0);
        cyc(6);
        chk_bits({5'h00, latch_open_q}, 6'h00);
        $display("parallel direct done");
    endtask
    task automatic t_ser;
        int m = n_mis;
        int r = n_rej;
        mode_serial = 1'b1;
        for (int a = 0; a < 8; a++) begin
            strap = 3'(a);
            cyc(4);
            frame({5'h1f, 3'(a)}, 8'(a * 5 + 3));
            chk_bits(atten_code_q, 6'(a * 5 + 3));
        end
        chk_bits({5'h00, mode_serial_q}, 6'h01);
        frame(8'h05, 8'h15);
        chk_bits(atten_code_q, 6'h26);
        chk_cnt(n_mis, m + 1);
        frame(8'h07, 8'h95);
        frame(8'h07, 8'h55);
        chk_bits(atten_code_q, 6'h26);
        chk_cnt(n_rej, r + 2);
        lm.send({12'h000, 8'h07, 8'h2b, 4'h9}, 20);
        cyc(2);
        pulse();
        chk_bits(atten_code_q, 6'h2b);
        while (!lm.rate_ok()) cyc(1);
        lm.set_le(1'b1);
        cyc(4);
        lm.send({16'h0000, 8'h07, 8'h11}, 16);
        cyc(8);
        chk_bits(atten_code_q, 6'h11);
        lm.set_le(1'b0);
        cyc(6);
        $display("serial done");
    endtask
    task automatic t_back;
        mode_serial = ~mode_serial;
        par = 6'h2c;
        cyc(6);
        chk_bits({5'h00, mode_serial_q}, 6'h00);
        chk_bits(atten_code_q, 6'h11);
        pulse();
        chk_bits(atten_code_q, 6'h2c);
        $display("mode back done");
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        lm.send(32'h0, 4);
        repeat (4) @(negedge mclk);
        nrst = 1'b1;
        cyc(2);
        t_par();
        t_direct();
        t_ser();
        t_back();
        end_of_test();
    end
    initial begin
        #1500000;
        num_errors++;
        $display("mismatch t=%0t watchdog", $time);
        end_of_test();
    end
endmodule
